// ### include/ppt_pkg.sv
// =====================================================================
// Shared constants for the programmed-I/O target
package ppt_pkg;
  // Region memory geometry
  localparam int RAM_AW = 9;
  localparam int RAM_WORDS = 512;
  localparam int NUM_REGIONS = 4;
  // Gathered descriptor and payload width
  localparam int GATHER_W = 256;
  // Request descriptor field positions
  localparam int DESC_AT_LSB = 0;
  localparam int DESC_ADDR_LSB = 2;
  localparam int DESC_DWCNT_LSB = 64;
  localparam int DESC_TYPE_LSB = 75;
  localparam int DESC_RID_LSB = 80;
  localparam int DESC_TAG_LSB = 96;
  localparam int DESC_BAR_LSB = 112;
  localparam int DESC_TC_LSB = 121;
  localparam int DESC_ATTR_LSB = 124;
  localparam int DESC_DATA_LSB = 128;
  // Request types
  localparam logic [3:0] REQ_MEM_RD = 4'h0;
  localparam logic [3:0] REQ_MEM_WR = 4'h1;
  localparam logic [3:0] REQ_IO_RD = 4'h2;
  localparam logic [3:0] REQ_IO_WR = 4'h3;
  // Aperture index map
  localparam logic [2:0] APT_MEM32 = 3'h0;
  localparam logic [2:0] APT_MEM64 = 3'h1;
  localparam logic [2:0] APT_EROM = 3'h6;
  // Region codes
  localparam logic [1:0] RGN_IO = 2'h0;
  localparam logic [1:0] RGN_MEM32 = 2'h1;
  localparam logic [1:0] RGN_MEM64 = 2'h2;
  localparam logic [1:0] RGN_EROM = 2'h3;
  // Magic trigger writes
  localparam logic [10:0] MAGIC_RD_ADDR = 11'h7AA;
  localparam logic [10:0] MAGIC_INT_ADDR = 11'h7BB;
  localparam logic [31:0] MAGIC_RD_DATA = 32'hAAAA_BBBB;
  localparam logic [31:0] MAGIC_LEG_DATA = 32'hCCCC_DDDD;
  localparam logic [31:0] MAGIC_MSI_DATA = 32'hEEEE_FFFF;
  localparam logic [31:0] MAGIC_MSIX_DATA = 32'hDEAD_BEEF;
  // Completion fields
  localparam logic [12:0] CPL_BYTE_CNT = 13'h0004;
  localparam logic [2:0] CPL_STATUS_SC = 3'h0;
  // APB register map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam int CTRL_IO_EN_BIT = 0;
  localparam int CTRL_IO_IDX_LSB = 4;
  localparam logic [2:0] IO_IDX_RST = 3'h0;
  localparam int STAT_DROP_LSB = 16;
  // Receive states, Gray coded
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_EXEC = 3'b011,
    ST_WR = 3'b010,
    ST_RD = 3'b110,
    ST_CPL = 3'b111
  } ppt_state_t;
endpackage

// ### design/ppt_region_ram.sv
`timescale 1ns/1ps
// =====================================================================
// One 2 KB dual-port region
module ppt_region_ram import ppt_pkg::*; (
  // Clock
  input wire logic clk_in,
  // Write port
  input wire logic we_in,
  input wire logic [RAM_AW-1:0] waddr_in,
  input wire logic [31:0] wdata_in,
  // Read port
  input wire logic [RAM_AW-1:0] raddr_in,
  output logic [31:0] rdata_out
);
  // Storage, one Dword per word
  logic [31:0] mem_q [RAM_WORDS];

  // =====================================================================
  // Write port
  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // Read port, one cycle latency
  always_ff @(posedge clk_in) begin
    rdata_out <= mem_q[raddr_in];
  end
endmodule // ppt_region_ram

// ### design/ppt_cpl_tx.sv
`timescale 1ns/1ps
// =====================================================================
// Completion sender: slices a completion into beats
module ppt_cpl_tx import ppt_pkg::*; #(
  parameter int DATA_W = 64
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Start request
  input wire logic start_in,
  input wire logic with_data_in,
  input wire logic [127:0] word_in,
  output logic done_out,
  // Completion stream
  output logic [DATA_W-1:0] tdata_out,
  output logic [DATA_W/32-1:0] tkeep_out,
  output logic tvalid_out,
  output logic tlast_out,
  input wire logic tready_in
);
  localparam int KW = DATA_W / 32;
  logic [GATHER_W-1:0] word_q; // Held completion, zero padded
  logic [2:0] ndw_q; // Dwords in this completion
  logic [2:0] beat_q; // Next beat index
  logic [KW-1:0] keep_d; // Keep for next beat
  logic last_d; // Next beat is last

  // Keep and last for the beat to present next
  always_comb begin
    keep_d = '0;
    for (int j = 0; j < KW; j++) begin
      keep_d[j] = (int'(beat_q) * KW + j) < int'(ndw_q);
    end
    last_d = (int'(beat_q) + 1) * KW >= int'(ndw_q);
  end

  // =====================================================================
  // Beats stand until tready
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      word_q <= '0;
      ndw_q <= '0;
      beat_q <= '0;
      tdata_out <= '0;
      tkeep_out <= '0;
      tvalid_out <= 1'b0;
      tlast_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        // Load and present first beat
        word_q <= {128'h0, word_in};
        ndw_q <= with_data_in ? 3'h4 : 3'h3;
        beat_q <= 3'h1;
        tdata_out <= word_in[DATA_W-1:0];
        tvalid_out <= 1'b1;
        tlast_out <= (KW >= 3) && (KW >= 4 || !with_data_in);
        for (int j = 0; j < KW; j++) begin
          tkeep_out[j] <= j < (with_data_in ? 4 : 3);
        end
      end else if (tvalid_out && tready_in) begin
        if (tlast_out) begin
          // Completion fully sent
          tvalid_out <= 1'b0;
          tlast_out <= 1'b0;
          done_out <= 1'b1;
        end else begin
          // Next slice
          tdata_out <= word_q[int'(beat_q) * DATA_W +: DATA_W];
          tkeep_out <= keep_d;
          tlast_out <= last_d;
          beat_q <= beat_q + 3'h1;
        end
      end
    end
  end
endmodule // ppt_cpl_tx

// ### design/ppt_pio_target.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
// Behaviour
// [RULE1] Four 2 KB block RAM regions, 8192 bytes
// [RULE2] 32-bit space, single-Dword memory and I/O access
// [RULE3] Reads return completion with one Dword
// [RULE4] I/O write gets success completion, memory none
// [RULE5] One-Dword write stores payload at address
// [RULE6] Write 0xAAAABBBB at 0x7AA starts read
// [RULE7] Write 0xCCCCDDDD at 0x7BB requests legacy interrupt
// [RULE8] Write 0xEEEEFFFF at 0x7BB requests MSI
// [RULE9] Write 0xDEADBEEF at 0x7BB requests MSI-X
// [RULE10] Aperture index from descriptor bits 114:112
// [RULE11] 000 mem32, 001 mem64, 110 expansion ROM
// [RULE12] Each region its own dual-port RAM
// [RULE13] Unserved apertures get no completion
// [RULE14] Low address bits only, large apertures wrap
// [RULE15] I/O aperture disabled by default, configurable
// [RULE16] Multi-Dword requests drained and dropped silently
// [RULE17] Core forwards only matching requests with handshake
// [RULE18] Region chosen from index before write enable
// [RULE19] Ready low during RAM write
// [RULE20] Builds for 64, 128 or 256-bit datapath
// [RULE21] Ready low until read completion generated
// [RULE22] Next request after completion fully sent
// [RULE23] Completion copies requester ID, tag, attributes
// [RULE24] Reads return Dword at low word address
module ppt_pio_target import ppt_pkg::*; #(
  parameter int DATA_W = 64 // 64, 128 or 256 [RULE20]
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  // Completer request stream from the core
  input wire logic [DATA_W-1:0] CQ_TDATA_IN,
  input wire logic CQ_TVALID_IN,
  input wire logic CQ_TLAST_IN,
  output logic COMPLETER_REQUEST_ACCEPT_OUT,
  // Completion stream to the core
  output logic [DATA_W-1:0] CC_TDATA_OUT,
  output logic [DATA_W/32-1:0] CC_TKEEP_OUT,
  output logic CC_TVALID_OUT,
  output logic CC_TLAST_OUT,
  input wire logic CC_TREADY_IN,
  // Trigger pulses
  output logic READ_REQ_OUT,
  output logic LEGACY_INT_REQ_OUT,
  output logic MSI_REQ_OUT,
  output logic MSIX_REQ_OUT,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT
);
  localparam int BEATS = GATHER_W / DATA_W;
  localparam int BW = $clog2(BEATS + 1);

  // =====================================================================
  // Reset release
  logic rst_meta_q; // First sync stage
  logic rst_n; // Synchronised reset

  // Two-stage reset release
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // =====================================================================
  // Declarations
  ppt_state_t state_q, state_d; // Receive state
  logic [GATHER_W-1:0] gather_q; // Gathered descriptor and payload
  logic [BW-1:0] beat_q; // Beats gathered
  logic accept_beat; // Request beat taken
  logic [3:0] req_type; // Request type
  logic [10:0] req_dwcnt; // Request length
  logic [2:0] req_bar; // Aperture index
  logic [31:0] req_data; // First payload Dword
  logic [2:0] hit; // {valid, region}
  logic is_wr; // Write request
  logic is_rd; // Read request
  logic [1:0] rgn_q; // Selected region
  logic [RAM_AW-1:0] waddr_q; // Word address in region
  logic [31:0] wdata_q; // Write data
  logic cpl_wr_q; // I/O write owes a completion
  logic [NUM_REGIONS-1:0] we_q; // Per-region write enables
  logic [31:0] rdata [NUM_REGIONS]; // Region read data
  logic tx_start_q; // Start completion
  logic tx_data_q; // Completion carries data
  logic [127:0] cpl_word; // Completion word
  logic tx_done; // Completion fully sent
  logic io_en_q; // I/O aperture enable
  logic [2:0] io_idx_q; // I/O aperture index
  logic [15:0] drop_cnt_q; // Dropped request count
  logic [10:0] local_addr; // Region plus word address

  // Descriptor fields [RULE10]
  assign req_type = gather_q[DESC_TYPE_LSB +: 4];
  assign req_dwcnt = gather_q[DESC_DWCNT_LSB +: 11];
  assign req_bar = gather_q[DESC_BAR_LSB +: 3];
  assign req_data = gather_q[DESC_DATA_LSB +: 32];
  assign is_wr = (req_type == REQ_MEM_WR) || (req_type == REQ_IO_WR); // [RULE2]
  assign is_rd = (req_type == REQ_MEM_RD) || (req_type == REQ_IO_RD); // [RULE2]
  assign accept_beat = COMPLETER_REQUEST_ACCEPT_OUT && CQ_TVALID_IN;
  assign local_addr = {rgn_q, waddr_q};

  // =====================================================================
  // Aperture decode: returns {valid, region}
  function automatic logic [2:0] region_of(input logic [3:0] typ, input logic [2:0] bar,
                                           input logic io_en, input logic [2:0] io_idx);
    logic [2:0] r;
    r = 3'h0;
    if (typ == REQ_IO_RD || typ == REQ_IO_WR) begin
      // Single I/O aperture, only when enabled [RULE15]
      if (io_en && bar == io_idx) begin
        r = {1'b1, RGN_IO};
      end
    end else if (typ == REQ_MEM_RD || typ == REQ_MEM_WR) begin
      // Memory aperture map [RULE11]
      unique case (bar)
        APT_MEM32: r = {1'b1, RGN_MEM32};
        APT_MEM64: r = {1'b1, RGN_MEM64};
        APT_EROM: r = {1'b1, RGN_EROM};
        default: r = 3'h0; // Other apertures unserved [RULE13]
      endcase
    end
    return r;
  endfunction

  assign hit = region_of(req_type, req_bar, io_en_q, io_idx_q);

  // =====================================================================
  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE, ST_RECV: begin
        // Take whole packet [RULE16]
        if (accept_beat && CQ_TLAST_IN) begin
          state_d = ST_EXEC;
        end else if (accept_beat) begin
          state_d = ST_RECV;
        end
      end
      ST_EXEC: begin
        if (!hit[2] || req_dwcnt != 11'h001 || !(is_wr || is_rd)) begin
          state_d = ST_IDLE; // Drop silently [RULE13] [RULE16]
        end else if (is_wr) begin
          state_d = ST_WR;
        end else begin
          state_d = ST_RD;
        end
      end
      ST_WR: begin
        // Only I/O write completes [RULE4]
        state_d = cpl_wr_q ? ST_CPL : ST_IDLE;
      end
      ST_RD: begin
        state_d = ST_CPL;
      end
      ST_CPL: begin
        // Wait for completion to leave [RULE22]
        if (tx_done) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Ready only while gathering
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      COMPLETER_REQUEST_ACCEPT_OUT <= 1'b0;
    end else begin
      COMPLETER_REQUEST_ACCEPT_OUT <= (state_d == ST_IDLE) || (state_d == ST_RECV); // [RULE19] [RULE21]
    end
  end

  // =====================================================================
  // Beat gathering
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      gather_q <= '0;
      beat_q <= '0;
    end else if (accept_beat) begin
      if (state_q == ST_IDLE) begin
        gather_q <= '0;
        gather_q[DATA_W-1:0] <= CQ_TDATA_IN;
        beat_q <= BW'(1);
      end else if (int'(beat_q) < BEATS) begin
        // Extra beats discarded
        gather_q[int'(beat_q) * DATA_W +: DATA_W] <= CQ_TDATA_IN;
        beat_q <= beat_q + BW'(1);
      end
    end
  end

  // =====================================================================
  // Capture at decode
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      rgn_q <= RGN_IO;
      waddr_q <= '0;
      wdata_q <= '0;
      cpl_wr_q <= 1'b0;
    end else if (state_q == ST_EXEC) begin
      rgn_q <= hit[1:0]; // Region picked before write enable [RULE18]
      waddr_q <= gather_q[DESC_ADDR_LSB +: RAM_AW]; // Low bits only, wraps [RULE14] [RULE24]
      wdata_q <= req_data;
      cpl_wr_q <= req_type == REQ_IO_WR;
    end
  end

  // Per-region write enable
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      we_q <= '0;
    end else begin
      we_q <= '0;
      if (state_d == ST_WR) begin
        we_q[hit[1:0]] <= 1'b1; // [RULE5] [RULE18]
      end
    end
  end

  // =====================================================================
  // Region memories
  for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_rgn
    // Own dual-port RAM per region [RULE1] [RULE12]
    ppt_region_ram u_ram (
      .clk_in(CLK_IN),
      .we_in(we_q[g]),
      .waddr_in(waddr_q),
      .wdata_in(wdata_q),
      .raddr_in(waddr_q),
      .rdata_out(rdata[g])
    );
  end

  // =====================================================================
  // Magic write triggers
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      READ_REQ_OUT <= 1'b0;
      LEGACY_INT_REQ_OUT <= 1'b0;
      MSI_REQ_OUT <= 1'b0;
      MSIX_REQ_OUT <= 1'b0;
    end else begin
      READ_REQ_OUT <= (state_q == ST_WR) && local_addr == MAGIC_RD_ADDR && wdata_q == MAGIC_RD_DATA; // [RULE6]
      LEGACY_INT_REQ_OUT <= (state_q == ST_WR) && local_addr == MAGIC_INT_ADDR
                            && wdata_q == MAGIC_LEG_DATA; // [RULE7]
      MSI_REQ_OUT <= (state_q == ST_WR) && local_addr == MAGIC_INT_ADDR && wdata_q == MAGIC_MSI_DATA; // [RULE8]
      MSIX_REQ_OUT <= (state_q == ST_WR) && local_addr == MAGIC_INT_ADDR && wdata_q == MAGIC_MSIX_DATA; // [RULE9]
    end
  end

  // =====================================================================
  // Completion build
  always_comb begin
    cpl_word = '0;
    cpl_word[6:0] = {gather_q[DESC_ADDR_LSB +: 5], 2'b00};
    cpl_word[9:8] = gather_q[DESC_AT_LSB +: 2];
    cpl_word[28:16] = CPL_BYTE_CNT;
    cpl_word[42:32] = tx_data_q ? 11'h001 : 11'h000; // One Dword payload [RULE3]
    cpl_word[45:43] = CPL_STATUS_SC; // Successful status [RULE4]
    cpl_word[63:48] = gather_q[DESC_RID_LSB +: 16]; // [RULE23]
    cpl_word[71:64] = gather_q[DESC_TAG_LSB +: 8]; // [RULE23]
    cpl_word[91:89] = gather_q[DESC_TC_LSB +: 3]; // [RULE23]
    cpl_word[94:92] = gather_q[DESC_ATTR_LSB +: 3]; // [RULE23]
    cpl_word[127:96] = rdata[rgn_q]; // Stored Dword [RULE24]
  end

  // Completion start pulse
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      tx_start_q <= 1'b0;
      tx_data_q <= 1'b0;
    end else begin
      tx_start_q <= (state_q == ST_RD) || (state_q == ST_WR && cpl_wr_q);
      tx_data_q <= state_q == ST_RD;
    end
  end

  // Completion sender
  ppt_cpl_tx #(.DATA_W(DATA_W)) u_tx (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n),
    .start_in(tx_start_q),
    .with_data_in(tx_data_q),
    .word_in(cpl_word),
    .done_out(tx_done),
    .tdata_out(CC_TDATA_OUT),
    .tkeep_out(CC_TKEEP_OUT),
    .tvalid_out(CC_TVALID_OUT),
    .tlast_out(CC_TLAST_OUT),
    .tready_in(CC_TREADY_IN)
  );

  // =====================================================================
  // Drop counter, saturating
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      drop_cnt_q <= '0;
    end else if (state_q == ST_EXEC && state_d == ST_IDLE && drop_cnt_q != 16'hFFFF) begin
      drop_cnt_q <= drop_cnt_q + 16'h0001;
    end
  end

  // =====================================================================
  // APB slave, one wait state
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      io_en_q <= 1'b0; // I/O aperture off [RULE15]
      io_idx_q <= IO_IDX_RST;
      PRDATA_OUT <= '0;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end else begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      if (PSEL_IN && PENABLE_IN && !PREADY_OUT) begin
        PREADY_OUT <= 1'b1;
        PRDATA_OUT <= '0;
        unique case (PADDR_IN)
          CTRL_OFS: begin
            // Control: I/O enable and index
            if (PWRITE_IN) begin
              io_en_q <= PWDATA_IN[CTRL_IO_EN_BIT];
              io_idx_q <= PWDATA_IN[CTRL_IO_IDX_LSB +: 3];
            end
            PRDATA_OUT[CTRL_IO_EN_BIT] <= io_en_q;
            PRDATA_OUT[CTRL_IO_IDX_LSB +: 3] <= io_idx_q;
          end
          STAT_OFS: begin
            // Status: state and dropped count
            PRDATA_OUT[2:0] <= state_q;
            PRDATA_OUT[STAT_DROP_LSB +: 16] <= drop_cnt_q;
          end
          default: PSLVERR_OUT <= 1'b1;
        endcase
      end
    end
  end
endmodule // ppt_pio_target

// ### verification/ppt_pio_target_props.sv
`timescale 1ns/1ps
// ==========
// Port checks of the target
module ppt_pio_target_props import ppt_pkg::*; #(
  parameter int DATA_W = 64
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  // Streams
  input wire logic [DATA_W-1:0] CQ_TDATA_IN,
  input wire logic CQ_TVALID_IN,
  input wire logic CQ_TLAST_IN,
  input wire logic COMPLETER_REQUEST_ACCEPT_OUT,
  input wire logic [DATA_W-1:0] CC_TDATA_OUT,
  input wire logic CC_TVALID_OUT,
  input wire logic CC_TREADY_IN,
  // Triggers
  input wire logic READ_REQ_OUT,
  input wire logic LEGACY_INT_REQ_OUT,
  input wire logic MSI_REQ_OUT,
  input wire logic MSIX_REQ_OUT
);
  // Request beat index, 64-bit lanes
  logic [1:0] bt_q;
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
    if (!ARST_N_IN) bt_q <= 2'h0;
    else if (CQ_TVALID_IN && COMPLETER_REQUEST_ACCEPT_OUT) bt_q <= CQ_TLAST_IN ? 2'h0 : bt_q + 2'h1;
  // Request end and read descriptor fields
  wire rq_end = CQ_TVALID_IN && CQ_TLAST_IN && COMPLETER_REQUEST_ACCEPT_OUT;
  wire rd_end = rq_end && bt_q == 2'h1 && CQ_TDATA_IN[14:11] == REQ_MEM_RD;
  wire [2:0] bar = CQ_TDATA_IN[50:48];
  wire one_dw = CQ_TDATA_IN[10:0] == 11'h001;
  wire served = bar == APT_MEM32 || bar == APT_MEM64 || bar == APT_EROM;
  wire [3:0] trig = {READ_REQ_OUT, LEGACY_INT_REQ_OUT, MSI_REQ_OUT, MSIX_REQ_OUT};
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  // ==========
  // Properties
  property p_acc_drop; rq_end |=> !COMPLETER_REQUEST_ACCEPT_OUT; endproperty
  a_acc_drop: assert property (p_acc_drop) else $error("accept high after request");
  property p_rd_cpl; rd_end && one_dw && served |-> ##[2:4] CC_TVALID_OUT; endproperty
  a_rd_cpl: assert property (p_rd_cpl) else $error("no read completion");
  property p_len; rd_end && !one_dw |=> !CC_TVALID_OUT [*4]; endproperty
  a_len: assert property (p_len) else $error("long read answered");
  property p_hold; CC_TVALID_OUT && !CC_TREADY_IN |=> CC_TVALID_OUT && $stable(CC_TDATA_OUT); endproperty
  a_hold: assert property (p_hold) else $error("completion beat dropped");
  property p_busy; CC_TVALID_OUT |-> !COMPLETER_REQUEST_ACCEPT_OUT; endproperty
  a_busy: assert property (p_busy) else $error("accept during completion");
  property p_fld; $rose(CC_TVALID_OUT) |-> CC_TDATA_OUT[28:16] == CPL_BYTE_CNT && CC_TDATA_OUT[45:43] == 3'h0;
  endproperty
  a_fld: assert property (p_fld) else $error("bad completion fields");
  property p_pulse; trig != 4'h0 |=> trig == 4'h0; endproperty
  a_pulse: assert property (p_pulse) else $error("trigger too long");
  property p_one; trig != 4'h0 |-> $onehot(trig); endproperty
  a_one: assert property (p_one) else $error("two triggers");
  // Main scenarios
  c_read: cover property (rd_end && one_dw && served);
  c_stall: cover property (CC_TVALID_OUT && !CC_TREADY_IN);
  c_msix: cover property (MSIX_REQ_OUT);
endmodule // ppt_pio_target_props
bind ppt_pio_target ppt_pio_target_props #(.DATA_W(DATA_W)) i_ppt_pio_target_props (.CLK_IN(CLK_IN),
  .ARST_N_IN(ARST_N_IN), .CQ_TDATA_IN(CQ_TDATA_IN), .CQ_TVALID_IN(CQ_TVALID_IN), .CQ_TLAST_IN(CQ_TLAST_IN),
  .COMPLETER_REQUEST_ACCEPT_OUT(COMPLETER_REQUEST_ACCEPT_OUT), .CC_TDATA_OUT(CC_TDATA_OUT),
  .CC_TVALID_OUT(CC_TVALID_OUT), .CC_TREADY_IN(CC_TREADY_IN), .READ_REQ_OUT(READ_REQ_OUT),
  .LEGACY_INT_REQ_OUT(LEGACY_INT_REQ_OUT), .MSI_REQ_OUT(MSI_REQ_OUT), .MSIX_REQ_OUT(MSIX_REQ_OUT));

// ### verification/ppt_core_model.sv
`timescale 1ns/1ps
// ==========
// Core side: request source, completion sink
module ppt_core_model import ppt_pkg::*; (
  // Request stream
  input wire logic clk_in,
  input wire logic accept_in,
  output logic [63:0] cq_data_out,
  output logic cq_valid_out = 1'b0,
  output logic cq_last_out,
  // Completion stream
  input wire logic [63:0] cc_data_in,
  input wire logic cc_valid_in,
  input wire logic cc_last_in,
  output logic cc_ready_out,
  input wire logic slow_in
);
  logic [127:0] cpl = '0; // Gathered completion
  logic got = 1'b0; // Last beat seen
  int bt = 0; // Beat index
  // Stall every other cycle when slow
  always @(posedge clk_in) cc_ready_out <= !slow_in || !cc_ready_out;
  // Gather completion beats
  always @(posedge clk_in) if (cc_valid_in && cc_ready_out) begin
    cpl[bt*64+:64] <= cc_data_in;
    bt <= cc_last_in ? 0 : bt + 1;
    got <= cc_last_in;
  end
  // Send one matching request, beat by beat
  task automatic send(input logic [3:0] t, input logic [2:0] b, input logic [11:0] a, input logic [10:0] n,
      input logic [31:0] d);
    logic [191:0] pk;
    int nb;
    pk = '0;
    pk[DESC_ADDR_LSB+:10] = a[11:2];
    pk[DESC_DWCNT_LSB+:11] = n;
    pk[DESC_TYPE_LSB+:4] = t;
    pk[DESC_RID_LSB+:16] = 16'hA5C3;
    pk[DESC_TAG_LSB+:8] = a[9:2];
    pk[DESC_BAR_LSB+:3] = b;
    pk[DESC_DATA_LSB+:32] = d;
    nb = t[0] ? 3 : 2;
    got = 1'b0;
    @(posedge clk_in);
    for (int i = 0; i < nb; i++) begin
      cq_data_out <= pk[i*64+:64];
      cq_valid_out <= 1'b1;
      cq_last_out <= i == nb - 1;
      do @(posedge clk_in); while (accept_in !== 1'b1);
    end
    // Released lines show inverted data
    cq_valid_out <= 1'b0;
    cq_last_out <= 1'b0;
    cq_data_out <= ~pk[(nb-1)*64+:64];
  endtask
endmodule // ppt_core_model

// ### verification/ppt_pio_target_bench.sv
`timescale 1ns/1ps
// ==========
// Self-checking bench for the target
module ppt_pio_target_bench;
  import ppt_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [63:0] cq_data, cc_data;
  logic cq_valid, cq_last, accept, cc_valid, cc_last, cc_ready;
  logic [1:0] cc_keep;
  logic [3:0] trig;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = '0, prdata;
  int n_mismatch = 0, total_checks = 0;
  int trig_cnt [4] = '{default: 0};
  initial forever #4 clk = ~clk;
  ppt_pio_target #(.DATA_W(64)) i_ppt_pio_target (.CLK_IN(clk), .ARST_N_IN(arst_n), .CQ_TDATA_IN(cq_data),
    .CQ_TVALID_IN(cq_valid), .CQ_TLAST_IN(cq_last), .COMPLETER_REQUEST_ACCEPT_OUT(accept),
    .CC_TDATA_OUT(cc_data), .CC_TKEEP_OUT(cc_keep), .CC_TVALID_OUT(cc_valid), .CC_TLAST_OUT(cc_last),
    .CC_TREADY_IN(cc_ready), .READ_REQ_OUT(trig[0]), .LEGACY_INT_REQ_OUT(trig[1]), .MSI_REQ_OUT(trig[2]),
    .MSIX_REQ_OUT(trig[3]), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
  ppt_core_model i_ppt_core_model (.clk_in(clk), .accept_in(accept), .cq_data_out(cq_data),
    .cq_valid_out(cq_valid), .cq_last_out(cq_last), .cc_data_in(cc_data), .cc_valid_in(cc_valid),
    .cc_last_in(cc_last), .cc_ready_out(cc_ready), .slow_in(slow));
  // Count trigger pulses
  always @(posedge clk) for (int k = 0; k < 4; k++) trig_cnt[k] += int'(trig[k] === 1'b1);
  // ==========
  // Shared tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Request, await completion
  task automatic req(input logic [3:0] t, input logic [2:0] b, input logic [11:0] a, input logic [10:0] n,
      input logic [31:0] d, input logic ex);
    i_ppt_core_model.send(t, b, a, n, d);
    for (int i = 0; i < 40 && i_ppt_core_model.got !== 1'b1; i++) @(posedge clk);
    chk(32'(i_ppt_core_model.got), 32'(ex));
  endtask
  task automatic rd(input logic [3:0] t, input logic [2:0] b, input logic [11:0] a, input logic [31:0] e);
    req(t, b, a, 11'h001, '0, 1'b1);
    chk(i_ppt_core_model.cpl[127:96], e);
    chk(32'(i_ppt_core_model.cpl[71:64]), 32'(a[9:2]));
    chk(32'(i_ppt_core_model.cpl[6:0]), 32'({a[6:2], 2'b00}));
  endtask
  // ==========
  // Scenarios
  task automatic t_regions();
    logic [2:0] bars [3] = '{APT_MEM32, APT_MEM64, APT_EROM};
    for (int i = 0; i < 3; i++) req(REQ_MEM_WR, bars[i], 12'h010, 11'h001, 32'h1234_0000 + i, 1'b0);
    for (int i = 0; i < 3; i++) rd(REQ_MEM_RD, bars[i], 12'h010, 32'h1234_0000 + i);
    req(REQ_MEM_WR, APT_MEM64, 12'h814, 11'h001, 32'h5A5A_0F0F, 1'b0);
    rd(REQ_MEM_RD, APT_MEM64, 12'h014, 32'h5A5A_0F0F);
  endtask
  task automatic t_drop();
    req(REQ_MEM_RD, APT_MEM32, 12'h010, 11'h002, '0, 1'b0);
    req(REQ_MEM_WR, APT_MEM32, 12'h010, 11'h002, 32'hFFFF_0000, 1'b0);
    req(REQ_MEM_RD, 3'h2, 12'h010, 11'h001, '0, 1'b0);
    req(REQ_IO_WR, 3'h2, 12'h020, 11'h001, 32'h0BAD_0BAD, 1'b0);
    rd(REQ_MEM_RD, APT_MEM32, 12'h010, 32'h1234_0000);
  endtask
  task automatic t_io();
    logic [31:0] r;
    logic e;
    apb(1'b0, CTRL_OFS, '0, r, e);
    chk(r, '0);
    apb(1'b0, 12'h008, '0, r, e);
    chk(32'(e), 32'h0000_0001);
    apb(1'b1, CTRL_OFS, 32'h0000_0021, r, e);
    req(REQ_IO_WR, 3'h2, 12'h020, 11'h001, 32'h00C0_FFEE, 1'b1);
    chk(32'(i_ppt_core_model.cpl[45:32]), '0);
    slow <= 1'b1;
    rd(REQ_IO_RD, 3'h2, 12'h020, 32'h00C0_FFEE);
    slow <= 1'b0;
  endtask
  task automatic t_magic();
    logic [31:0] dt [5] = '{MAGIC_RD_DATA, MAGIC_LEG_DATA, MAGIC_MSI_DATA, MAGIC_MSIX_DATA, 32'h1111_2222};
    int c [4];
    for (int i = 0; i < 5; i++) begin
      c = trig_cnt;
      req(REQ_MEM_WR, APT_EROM, i ? 12'h6EC : 12'h6A8, 11'h001, dt[i], 1'b0);
      for (int k = 0; k < 4; k++) chk(32'(trig_cnt[k] - c[k]), 32'(k == i));
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regions();
    t_drop();
    t_io();
    t_magic();
    give_verdict();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
endmodule // ppt_pio_target_bench
